/* testbench/pdr_host_model.sv */
`timescale 1ns/100ps
// ****************************************************************
// serial engine stand-in issuing byte strobes
// ****************************************************************
module pdr_host_model import pdr_pkg::*; (
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    input  wire logic       rvalid_i,
    output pdr_cfg_req_t    req_o
);
    int         rv_count;
    logic [7:0] rv_data;
    initial begin
        rv_count = 0;
        req_o    = '0;
    end
    // catch each answer at the sampling edge, whatever its latency
    always @(posedge clk_i) begin
        if (rvalid_i === 1'b1) begin
            rv_count <= rv_count + 1;
            rv_data  <= rdata_i;
        end
    end
    // one strobe cycle; address and data are inverted once released
    task automatic strobe(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        req_o <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge clk_i);
        req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask : strobe
    // read with a bounded wait; ok stays low when no answer came
    task automatic read(input logic [7:0] a, output logic [7:0] d, output logic ok);
        int n;
        n = rv_count;
        strobe(1'b0, a, 8'h00);
        for (int k = 0; k < 4 && rv_count == n; k++) begin
            @(negedge clk_i);
        end
        ok = (rv_count == n + 1);
        d  = rv_data;
    endtask : read
endmodule : pdr_host_model

/* testbench/pdr_regs_sva.sv */
`timescale 1ns/100ps
// ****************************************************************
// register slice checker
// ****************************************************************
module pdr_regs_sva import pdr_pkg::*; (
    input wire logic         clk_i,
    input wire logic         srst_i,
    input wire pdr_cfg_req_t cfg_req_i,
    input wire logic [7:0]   cfg_rdata_o,
    input wire logic         cfg_rvalid_o,
    input wire pdr_pll_b_t   pll_b_cfg_o,
    input wire pdr_pll_c_t   pll_c_cfg_o,
    input wire pdr_pll_d_t   pll_d_cfg_o,
    input wire pdr_out_div_t out_div_o,
    input wire pdr_source_t  out3_src_o,
    input wire pdr_source_t  out4_src_o,
    input wire pdr_source_t  out5_src_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    // write strobe to one address; outputs follow two edges later
    sequence s_wr(logic [7:0] a);
        cfg_req_i.wr && cfg_req_i.addr == a;
    endsequence
    // divider five source as its select field encodes it
    function automatic pdr_source_t out5_source_sel(logic [1:0] s);
        case (s)
            2'h1: return SRC_THIRD_PLL;
            2'h2: return SRC_FIRST_PLL;
            2'h3: return SRC_SECOND_PLL;
            default: return SRC_OFF;
        endcase
    endfunction : out5_source_sel
    AST_RD_ANSWER: assert property (cfg_req_i.rd |=> cfg_rvalid_o)
        else $error("read strobe got no answer");
    AST_RDATA_HOLD: assert property (!cfg_rvalid_o |-> $stable(cfg_rdata_o))
        else $error("read data moved without an answer");
    AST_REF_C: assert property (s_wr(8'h1B) |-> ##2
        pll_c_cfg_o.ref_div == $past(cfg_req_i.wdata, 2)) else $error("third ref divider wrong");
    AST_FB_C_HI: assert property (s_wr(8'h1C) |-> ##2
        pll_c_cfg_o.fb_div[10:3] == $past(cfg_req_i.wdata, 2)) else $error("third fb high wrong");
    AST_FB_C_LO: assert property (s_wr(8'h1D) |-> ##2
        pll_c_cfg_o.fb_div[2:0] == $past(cfg_req_i.wdata[2:0], 2))
        else $error("third fb low wrong");
    AST_PREDIV_EN: assert property (s_wr(8'h1F) |-> ##2
        pll_c_cfg_o.prediv_en == $past(cfg_req_i.wdata[1], 2))
        else $error("predivider enable wrong");
    AST_B_SEL: assert property (s_wr(8'h1A) |-> ##2
        pll_b_cfg_o.input_sel == pdr_ref_t'($past(cfg_req_i.wdata[1], 2)))
        else $error("second pll input select wrong");
    AST_PREDIV_BYPASS: assert property (!pll_c_cfg_o.prediv_en |->
        pll_c_cfg_o.fb_prediv == 8'h00) else $error("predivider applied while bypassed");
    AST_REF_D: assert property (s_wr(8'h20) |-> ##2
        pll_d_cfg_o.ref_div == $past(cfg_req_i.wdata, 2)) else $error("fourth ref divider wrong");
    AST_FB_D_HI: assert property (s_wr(8'h21) |-> ##2
        pll_d_cfg_o.fb_div[10:3] == $past(cfg_req_i.wdata, 2)) else $error("fourth fb high wrong");
    AST_OD5: assert property (s_wr(8'h2B) |-> ##2
        out_div_o[5] == $past(cfg_req_i.wdata, 2)) else $error("divider five value wrong");
    AST_OUT5_SOURCE_SEL: assert property (s_wr(8'h2D) |-> ##2
        out5_src_o == out5_source_sel($past(cfg_req_i.wdata[5:4], 2)))
        else $error("divider five source wrong");
    // without a write neither the output dividers nor the third pll may move: a leaky register shows here
    AST_HOLD: assert property (!cfg_req_i.wr |-> ##2
        $stable(out_div_o) && $stable(pll_c_cfg_o))
        else $error("configuration changed without a write");
endmodule : pdr_regs_sva

bind pdr_regs pdr_regs_sva i_sva (.clk_i(clk_i), .srst_i(srst_i), .cfg_req_i(cfg_req_i),
    .cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(cfg_rvalid_o), .pll_b_cfg_o(pll_b_cfg_o),
    .pll_c_cfg_o(pll_c_cfg_o), .pll_d_cfg_o(pll_d_cfg_o), .out_div_o(out_div_o),
    .out3_src_o(out3_src_o), .out4_src_o(out4_src_o), .out5_src_o(out5_src_o));

/* testbench/tb_top.sv */
`timescale 1ns/100ps
// ****************************************************************
// testbench top
// ****************************************************************
module tb_top import pdr_pkg::*; ;
    logic         clk;
    logic         srst;
    pdr_cfg_req_t req;
    logic [7:0]   rdata;
    logic         rvalid;
    pdr_pll_b_t   b_cfg;
    pdr_pll_c_t   c_cfg;
    pdr_pll_d_t   d_cfg;
    pdr_out_div_t out_div;
    pdr_source_t  out3_source_sel, out4_source_sel, out5_source_sel;
    int           num_errors = 0;
    int           check_count = 0;
    logic [7:0]   rd_val;
    logic         rd_ok;
    logic [7:0]   wmask [21] = '{8'h7F, 8'h03, 8'hFF, 8'hFF, 8'h07, 8'hFF, 8'hFB, 8'hFF, 8'hFF,
        8'h07, 8'h7F, 8'hFF, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h3F};
    logic [7:0]   od_addr [6] = '{8'h24, 8'h26, 8'h27, 8'h29, 8'h2A, 8'h2B};
    pdr_source_t  e3 [4] = '{SRC_OFF, SRC_MHZ_REF, SRC_32K_REF, SRC_FOURTH_PLL};
    pdr_source_t  e4 [4] = '{SRC_OFF, SRC_THIRD_PLL, SRC_MHZ_REF, SRC_32K_REF};
    pdr_source_t  e5 [4] = '{SRC_OFF, SRC_THIRD_PLL, SRC_FIRST_PLL, SRC_SECOND_PLL};
    pdr_regs i_dut (.clk_i(clk), .srst_i(srst), .cfg_req_i(req), .cfg_rdata_o(rdata),
        .cfg_rvalid_o(rvalid), .pll_b_cfg_o(b_cfg), .pll_c_cfg_o(c_cfg), .pll_d_cfg_o(d_cfg),
        .out_div_o(out_div), .out3_src_o(out3_source_sel), .out4_src_o(out4_source_sel), .out5_src_o(out5_source_sel));
    pdr_host_model i_host (.clk_i(clk), .rdata_i(rdata), .rvalid_i(rvalid), .req_o(req));
    // 20 MHz clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic test_done();
        if (num_errors == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done
    task automatic chk(input string name, input logic [10:0] exp, input logic [10:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // a lost answer counts as an error and ends the run there
    task automatic reg_chk(input logic [7:0] a, input logic [7:0] exp);
        i_host.read(a, rd_val, rd_ok);
        if (rd_ok !== 1'b1) begin
            num_errors++;
            $display("Error read answer %h expected 1 seen 0", a);
            test_done();
        end else begin
            chk($sformatf("reg %h", a), {3'h0, exp}, {3'h0, rd_val});
        end
    endtask : reg_chk
    // outputs follow a write two edges later
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic settle);
        i_host.strobe(1'b1, a, d);
        if (settle) repeat (2) @(negedge clk);
    endtask : wr
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_reset_and_masks();
        for (int a = 8'h18; a <= 8'h2E; a++) begin
            reg_chk(8'(a), (a == 8'h19) ? 8'h40 : 8'h00);
        end
        for (int a = 8'h18; a <= 8'h2E; a++) wr(8'(a), 8'hFF, 1'b0);
        for (int a = 8'h18; a <= 8'h2E; a++) begin
            reg_chk(8'(a), (a < 8'h19 || a > 8'h2D) ? 8'h00 : wmask[a - 8'h19]);
        end
        chk("c fb", 11'h7FF, c_cfg.fb_div);
        chk("c prediv", 11'h0FF, {3'h0, c_cfg.fb_prediv});
        chk("d sel", 11'h003, {9'h0, d_cfg.input_sel});
    endtask : t_reset_and_masks
    task automatic t_pll_c_d();
        wr(8'h1B, 8'hA5, 1'b0);
        wr(8'h1C, 8'h96, 1'b0);
        wr(8'h1D, 8'hFD, 1'b0);
        wr(8'h1E, 8'h3C, 1'b0);
        wr(8'h20, 8'h5A, 1'b0);
        wr(8'h21, 8'h69, 1'b0);
        wr(8'h22, 8'hFA, 1'b0);
        wr(8'h1F, 8'h01, 1'b1);
        chk("c ref", 11'h0A5, {3'h0, c_cfg.ref_div});
        chk("c fb", 11'h4B5, c_cfg.fb_div);
        chk("c bypass", 11'h000, {2'h0, c_cfg.prediv_en, c_cfg.fb_prediv});
        chk("c sel", {10'h0, REF_32K}, {10'h0, c_cfg.input_sel});
        chk("d ref", 11'h05A, {3'h0, d_cfg.ref_div});
        chk("d fb", 11'h34A, d_cfg.fb_div);
        wr(8'h1F, 8'h02, 1'b1);
        chk("c prediv", 11'h13C, {2'h0, c_cfg.prediv_en, c_cfg.fb_prediv});
        chk("c sel", {10'h0, REF_MHZ}, {10'h0, c_cfg.input_sel});
    endtask : t_pll_c_d
    task automatic t_out_div();
        for (int i = 0; i < 6; i++) wr(od_addr[i], 8'(8'h11 * (i + 1)), 1'b1);
        for (int i = 0; i < 6; i++) begin
            chk("out div", 11'(8'h11 * (i + 1)), {3'h0, out_div[i]});
        end
        chk("c ref kept", 11'h0A5, {3'h0, c_cfg.ref_div});
    endtask : t_out_div
    task automatic t_routing_and_b();
        for (int s = 0; s < 4; s++) begin
            wr(8'h2D, {2'h0, 2'(s), 2'(s), 2'(s)}, 1'b1);
            chk("out5_source_sel", {8'h0, e5[s]}, {8'h0, out5_source_sel});
            chk("out4_source_sel", {8'h0, e4[s]}, {8'h0, out4_source_sel});
            chk("out3_source_sel", {8'h0, e3[s]}, {8'h0, out3_source_sel});
        end
        wr(8'h1A, 8'h02, 1'b1);
        chk("b sel", {9'h0, REF_32K, 1'b0}, {9'h0, b_cfg});
        wr(8'h1A, 8'h01, 1'b1);
        chk("b sel", {9'h0, REF_MHZ, 1'b1}, {9'h0, b_cfg});
    endtask : t_routing_and_b
    // reset for 12 cycles, then every scenario in turn
    initial begin
        srst = 1'b1;
        repeat (12) @(negedge clk);
        srst = 1'b0;
        t_reset_and_masks();
        t_pll_c_d();
        t_out_div();
        t_routing_and_b();
        test_done();
    end
endmodule : tb_top

/* verilog/pdr_pkg.sv */
package pdr_pkg;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [7:0] ADDR_FIRST      = 8'h19;
    localparam logic [7:0] ADDR_LAST       = 8'h2D;
    localparam int         NUM_REGS        = 21;
    localparam logic [7:0] PLL_B_LOOP      = 8'h19;
    localparam logic [7:0] PLL_B_INPUT     = 8'h1A;
    localparam logic [7:0] PLL_C_REF       = 8'h1B;
    localparam logic [7:0] PLL_C_FB_HIGH   = 8'h1C;
    localparam logic [7:0] PLL_C_FB_LOW    = 8'h1D;
    localparam logic [7:0] PLL_C_PREDIV    = 8'h1E;
    localparam logic [7:0] PLL_C_LOOP      = 8'h1F;
    localparam logic [7:0] PLL_D_REF       = 8'h20;
    localparam logic [7:0] PLL_D_FB_HIGH   = 8'h21;
    localparam logic [7:0] PLL_D_FB_LOW    = 8'h22;
    localparam logic [7:0] PLL_D_LOOP      = 8'h23;
    localparam logic [7:0] OUT_DIV_ZERO    = 8'h24;
    localparam logic [7:0] SPARE_A         = 8'h25;
    localparam logic [7:0] OUT_DIV_ONE     = 8'h26;
    localparam logic [7:0] OUT_DIV_TWO     = 8'h27;
    localparam logic [7:0] SPARE_B         = 8'h28;
    localparam logic [7:0] OUT_DIV_THREE   = 8'h29;
    localparam logic [7:0] OUT_DIV_FOUR    = 8'h2A;
    localparam logic [7:0] OUT_DIV_FIVE    = 8'h2B;
    localparam logic [7:0] SPARE_C         = 8'h2C;
    localparam logic [7:0] OUT_SRC_ROUTING = 8'h2D;

    // ****************************************************************
    // reset values and writable-bit masks
    // ****************************************************************
    localparam logic [7:0] RST_PLL_B_LOOP  = 8'h40;
    localparam logic [7:0] RST_DEFAULT     = 8'h00;
    localparam logic [7:0] MASK_FULL       = 8'hFF;
    localparam logic [7:0] MASK_NONE       = 8'h00;
    localparam logic [7:0] MASK_PLL_B_LOOP = 8'h7F;
    localparam logic [7:0] MASK_PLL_B_IN   = 8'h03;
    localparam logic [7:0] MASK_FB_LOW     = 8'h07;
    localparam logic [7:0] MASK_PLL_C_LOOP = 8'hFB;
    localparam logic [7:0] MASK_PLL_D_LOOP = 8'h7F;
    localparam logic [7:0] MASK_ROUTING    = 8'h3F;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int B_SPREAD_EN_BIT = 0;
    localparam int B_INPUT_SEL_BIT = 1;
    localparam int C_INPUT_SEL_BIT = 0;
    localparam int C_PREDIV_EN_BIT = 1;
    localparam int D_INPUT_SEL_LSB = 0;
    localparam int OUT3_SOURCE_SEL_LSB        = 0;
    localparam int OUT4_SOURCE_SEL_LSB        = 2;
    localparam int OUT5_SOURCE_SEL_LSB        = 4;
    localparam int NUM_OUT_DIV     = 6;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [2:0] {
        SRC_OFF,
        SRC_FIRST_PLL,
        SRC_SECOND_PLL,
        SRC_THIRD_PLL,
        SRC_FOURTH_PLL,
        SRC_MHZ_REF,
        SRC_32K_REF
    } pdr_source_t;

    typedef enum logic {
        REF_MHZ,
        REF_32K
    } pdr_ref_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pdr_cfg_req_t;

    typedef struct packed {
        pdr_ref_t   input_sel;
        logic       spread_en;
    } pdr_pll_b_t;

    typedef struct packed {
        logic [7:0]  ref_div;
        logic [10:0] fb_div;
        logic        prediv_en;
        logic [7:0]  fb_prediv;
        pdr_ref_t    input_sel;
    } pdr_pll_c_t;

    typedef struct packed {
        logic [7:0]  ref_div;
        logic [10:0] fb_div;
        logic [1:0]  input_sel;
    } pdr_pll_d_t;

    typedef logic [NUM_OUT_DIV-1:0][7:0] pdr_out_div_t;

endpackage : pdr_pkg

/* verilog/pdr_regs.sv */
`timescale 1ns/100ps

// ****************************************************************
// pll divider and output routing register slice
// ****************************************************************
module pdr_regs import pdr_pkg::*; (
    input  wire logic          clk_i,
    input  wire logic          srst_i,
    input  wire pdr_cfg_req_t  cfg_req_i,
    output logic [7:0]         cfg_rdata_o,
    output logic               cfg_rvalid_o,
    output pdr_pll_b_t         pll_b_cfg_o,
    output pdr_pll_c_t         pll_c_cfg_o,
    output pdr_pll_d_t         pll_d_cfg_o,
    output pdr_out_div_t       out_div_o,
    output pdr_source_t        out3_src_o,
    output pdr_source_t        out4_src_o,
    output pdr_source_t        out5_src_o
);

    // ****************************************************************
    // per-address helpers
    // ****************************************************************

    // reserved bits are never stored, so they always read back as zero
    function automatic logic [7:0] wr_mask(input logic [7:0] addr);
        logic [7:0] m;
        m = MASK_FULL;
        if (addr == PLL_B_LOOP) begin
            m = MASK_PLL_B_LOOP;
        end else if (addr == PLL_B_INPUT) begin
            m = MASK_PLL_B_IN;
        end else if (addr == PLL_C_FB_LOW || addr == PLL_D_FB_LOW) begin
            m = MASK_FB_LOW;
        end else if (addr == PLL_C_LOOP) begin
            m = MASK_PLL_C_LOOP;
        end else if (addr == PLL_D_LOOP) begin
            m = MASK_PLL_D_LOOP;
        end else if (addr == SPARE_A || addr == SPARE_B || addr == SPARE_C) begin
            m = MASK_NONE;
        end else if (addr == OUT_SRC_ROUTING) begin
            m = MASK_ROUTING;
        end
        return m;
    endfunction : wr_mask

    function automatic logic [7:0] rst_val(input logic [7:0] addr);
        logic [7:0] v;
        v = RST_DEFAULT;
        if (addr == PLL_B_LOOP) begin
            v = RST_PLL_B_LOOP;
        end
        return v;
    endfunction : rst_val

    // ****************************************************************
    // register storage
    // ****************************************************************
    logic [7:0] regs [NUM_REGS];
    logic       in_range;
    logic [4:0] idx;

    assign in_range = (cfg_req_i.addr >= ADDR_FIRST) && (cfg_req_i.addr <= ADDR_LAST);
    assign idx      = 5'(cfg_req_i.addr - ADDR_FIRST);

    // fields keep their value until software rewrites them
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < NUM_REGS; i++) begin
            if (srst_i) begin
                regs[i] <= rst_val(8'(ADDR_FIRST + i));
            end else if (cfg_req_i.wr && in_range && idx == 5'(i)) begin
                regs[i] <= cfg_req_i.wdata & wr_mask(cfg_req_i.addr);
            end
        end
    end

    // read port: answers one cycle after the request, zero when unmapped
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cfg_rdata_o  <= 8'h00;
            cfg_rvalid_o <= 1'b0;
        end else begin
            cfg_rvalid_o <= cfg_req_i.rd;
            if (cfg_req_i.rd) begin
                cfg_rdata_o <= in_range ? regs[idx] : 8'h00;
            end
        end
    end

    // ****************************************************************
    // field views
    // ****************************************************************

    // views index the array directly: a continuous assign wakes only on its
    // own operands, so a helper that reads the array behind them goes stale
    logic [7:0] b_input;
    logic [7:0] c_ref;
    logic [7:0] c_fb_high;
    logic [7:0] c_fb_low;
    logic [7:0] c_prediv;
    logic [7:0] c_loop;
    logic [7:0] d_ref;
    logic [7:0] d_fb_high;
    logic [7:0] d_fb_low;
    logic [7:0] d_loop;
    logic [7:0] routing;

    // second and third pll registers
    assign b_input   = regs[5'(PLL_B_INPUT - ADDR_FIRST)];
    assign c_ref     = regs[5'(PLL_C_REF - ADDR_FIRST)];
    assign c_fb_high = regs[5'(PLL_C_FB_HIGH - ADDR_FIRST)];
    assign c_fb_low  = regs[5'(PLL_C_FB_LOW - ADDR_FIRST)];
    assign c_prediv  = regs[5'(PLL_C_PREDIV - ADDR_FIRST)];
    assign c_loop    = regs[5'(PLL_C_LOOP - ADDR_FIRST)];

    // fourth pll registers and the routing byte
    assign d_ref     = regs[5'(PLL_D_REF - ADDR_FIRST)];
    assign d_fb_high = regs[5'(PLL_D_FB_HIGH - ADDR_FIRST)];
    assign d_fb_low  = regs[5'(PLL_D_FB_LOW - ADDR_FIRST)];
    assign d_loop    = regs[5'(PLL_D_LOOP - ADDR_FIRST)];
    assign routing   = regs[5'(OUT_SRC_ROUTING - ADDR_FIRST)];

    // ****************************************************************
    // pll configuration outputs
    // ****************************************************************

    // second pll: single select bit picks the reference input
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pll_b_cfg_o <= '{input_sel: REF_MHZ, spread_en: 1'b0};
        end else begin
            pll_b_cfg_o.input_sel <= b_input[B_INPUT_SEL_BIT]
                                     ? REF_32K : REF_MHZ;
            pll_b_cfg_o.spread_en <= b_input[B_SPREAD_EN_BIT];
        end
    end

    // third pll dividers; the predivider value is zero while bypassed
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pll_c_cfg_o <= '0;
        end else begin
            pll_c_cfg_o.ref_div   <= c_ref;
            pll_c_cfg_o.fb_div    <= {c_fb_high, c_fb_low[2:0]};
            pll_c_cfg_o.prediv_en <= c_loop[C_PREDIV_EN_BIT];
            pll_c_cfg_o.fb_prediv <= c_loop[C_PREDIV_EN_BIT]
                                     ? c_prediv : 8'h00;
            pll_c_cfg_o.input_sel <= c_loop[C_INPUT_SEL_BIT] ? REF_32K : REF_MHZ;
        end
    end

    // fourth pll dividers and its two-bit input select
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pll_d_cfg_o <= '0;
        end else begin
            pll_d_cfg_o.ref_div   <= d_ref;
            pll_d_cfg_o.fb_div    <= {d_fb_high, d_fb_low[2:0]};
            pll_d_cfg_o.input_sel <= d_loop[D_INPUT_SEL_LSB +: 2];
        end
    end

    // ****************************************************************
    // output dividers
    // ****************************************************************

    // the map skips spare slots, so the dividers are not contiguous
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            out_div_o <= '0;
        end else begin
            out_div_o[0] <= regs[5'(OUT_DIV_ZERO - ADDR_FIRST)];
            out_div_o[1] <= regs[5'(OUT_DIV_ONE - ADDR_FIRST)];
            out_div_o[2] <= regs[5'(OUT_DIV_TWO - ADDR_FIRST)];
            out_div_o[3] <= regs[5'(OUT_DIV_THREE - ADDR_FIRST)];
            out_div_o[4] <= regs[5'(OUT_DIV_FOUR - ADDR_FIRST)];
            out_div_o[5] <= regs[5'(OUT_DIV_FIVE - ADDR_FIRST)];
        end
    end

    // ****************************************************************
    // output source routing
    // ****************************************************************
    pdr_source_t next_out3_source_sel;
    pdr_source_t next_out4_source_sel;
    pdr_source_t next_out5_source_sel;

    // each divider has its own encoding of the same code points
    always_comb begin
        case (routing[OUT5_SOURCE_SEL_LSB +: 2])
            2'h1:    next_out5_source_sel = SRC_THIRD_PLL;
            2'h2:    next_out5_source_sel = SRC_FIRST_PLL;
            2'h3:    next_out5_source_sel = SRC_SECOND_PLL;
            default: next_out5_source_sel = SRC_OFF;
        endcase
        case (routing[OUT4_SOURCE_SEL_LSB +: 2])
            2'h1:    next_out4_source_sel = SRC_THIRD_PLL;
            2'h2:    next_out4_source_sel = SRC_MHZ_REF;
            2'h3:    next_out4_source_sel = SRC_32K_REF;
            default: next_out4_source_sel = SRC_OFF;
        endcase
        case (routing[OUT3_SOURCE_SEL_LSB +: 2])
            2'h1:    next_out3_source_sel = SRC_MHZ_REF;
            2'h2:    next_out3_source_sel = SRC_32K_REF;
            2'h3:    next_out3_source_sel = SRC_FOURTH_PLL;
            default: next_out3_source_sel = SRC_OFF;
        endcase
    end

    // registered so the clock matrix never sees a decode glitch
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            out3_src_o <= SRC_OFF;
            out4_src_o <= SRC_OFF;
            out5_src_o <= SRC_OFF;
        end else begin
            out3_src_o <= next_out3_source_sel;
            out4_src_o <= next_out4_source_sel;
            out5_src_o <= next_out5_source_sel;
        end
    end

endmodule : pdr_regs
